// ### shared/sfd_pkg.sv
// Notes on behaviour
// [RULE_01] Ten channels: one high-voltage, four positive, five dual-function inputs.
// [RULE_02] A dual-function input is either a fault detector or a logic input.
// [RULE_03] Each detector flags undervoltage, overvoltage or out-of-window.
// [RULE_04] Thresholds are 8-bit codes scaled bottom plus span times N over 255.
// [RULE_05] Four ranges; high input upper two, positive lower three, dual lowest.
// [RULE_06] Hysteresis applies once a fault asserts, widening the clear level.
// [RULE_07] Hysteresis is a 5-bit code, span times code over 255.
// [RULE_08] A glitch filter ends every detector, timeout 0 to 100 us.
// [RULE_09] Pulses shorter than the timeout are dropped, longer ones pass.
// [RULE_10] A passed pulse is delayed by the programmed timeout.
// [RULE_11] Comparators evaluate every cycle, never by intermittent sampling.
// [RULE_12] Window mode ORs undervoltage and overvoltage results, each with hysteresis.
package sfd_pkg;

   // ****************************************
   // Channel layout
   // ****************************************
   localparam int NUM_CHAN   = 10;
   localparam int NUM_DUAL   = 5;
   localparam int FIRST_DUAL = 5;
   localparam int HV_CHAN    = 0;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [7:0] OFS_CFG_BASE   = 8'h00;
   localparam logic [7:0] OFS_FILT_BASE  = 8'h40;
   localparam logic [7:0] OFS_RANGE_BASE = 8'h80;
   localparam logic [7:0] OFS_STATUS     = 8'hC0;
   localparam logic [7:0] OFS_RAW        = 8'hC4;
   localparam logic [7:0] OFS_LOGIC      = 8'hC8;

   // Channel config word fields
   localparam int CFG_UV_LSB    = 0;
   localparam int CFG_OV_LSB    = 8;
   localparam int CFG_HYST_LSB  = 16;
   localparam int CFG_MODE_LSB  = 21;
   localparam int CFG_RANGE_LSB = 23;
   localparam int CFG_DIG_BIT   = 25;
   localparam int FILT_US_W     = 7;

   // ****************************************
   // Modes and ranges
   // ****************************************
   localparam logic [1:0] MODE_UNDER  = 2'h0;
   localparam logic [1:0] MODE_OVER   = 2'h1;
   localparam logic [1:0] MODE_WINDOW = 2'h2;

   localparam logic [1:0] RANGE_0573 = 2'h0;
   localparam logic [1:0] RANGE_1250 = 2'h1;
   localparam logic [1:0] RANGE_2500 = 2'h2;
   localparam logic [1:0] RANGE_6000 = 2'h3;

   // Range bottom and span, millivolts
   localparam logic [15:0] BOT_MV_0 = 16'd573;
   localparam logic [15:0] SPN_MV_0 = 16'd802;
   localparam logic [15:0] BOT_MV_1 = 16'd1250;
   localparam logic [15:0] SPN_MV_1 = 16'd1750;
   localparam logic [15:0] BOT_MV_2 = 16'd2500;
   localparam logic [15:0] SPN_MV_2 = 16'd3500;
   localparam logic [15:0] BOT_MV_3 = 16'd6000;
   localparam logic [15:0] SPN_MV_3 = 16'd8400;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS  = 40;
   localparam int FILT_MAX_US    = 100;
   localparam int CYC_PER_US     = 1000 / CLK_PERIOD_NS;
   localparam int FILT_CNT_W     = 12;
   localparam logic [6:0] FILT_MAX_US_CODE = 7'(FILT_MAX_US);

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic       digital;
      logic [1:0] range;
      logic [1:0] mode;
      logic [4:0] hyst;
      logic [7:0] ov_thr;
      logic [7:0] uv_thr;
   } sfd_chan_cfg_type;

   typedef struct packed {
      logic [7:0] ofs;
      logic       write;
      logic       valid;
   } sfd_bus_req_type;

endpackage

// ### src/sfd_glitch_filter.sv
module sfd_glitch_filter
   import sfd_pkg::*;
(
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_resetn,
   input  wire logic                  i_clk_en,
   input  wire logic                  i_raw,
   input  wire logic [FILT_CNT_W-1:0] i_limit,
   output logic                       o_filtered
);

   logic [FILT_CNT_W-1:0] run_cnt;

   // ****************************************
   // Stability counter
   // ****************************************
   // Counts cycles the input disagrees with the output; any return resets it
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         run_cnt <= '0;
      end else if (i_clk_en) begin
         if (i_raw == o_filtered || run_cnt >= i_limit) begin
            run_cnt <= '0;                                   // [RULE_09]
         end else begin
            run_cnt <= run_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_filtered <= 1'b0;
      end else if (i_clk_en && i_raw != o_filtered && run_cnt >= i_limit) begin
         o_filtered <= i_raw;                                // [RULE_10]
      end
   end

   chk_filter_wait_full: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_09]
      (o_filtered != $past(o_filtered)) |-> ($past(run_cnt) == $past(i_limit) && $past(i_raw) == o_filtered))
      else $error("filter output moved before timeout");

   chk_filter_passes: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_10]
      (i_clk_en && i_raw != o_filtered && run_cnt == i_limit) |=> (o_filtered == $past(i_raw)))
      else $error("stable input not passed at timeout");

endmodule

// ### src/sfd_channels_top.sv
// The placing of the registers and register access over AHB-Lite were left to the implementer.
module sfd_channels_top
   import sfd_pkg::*;
(
   input  wire logic                      i_sys_clk,
   input  wire logic                      i_resetn,
   input  wire logic                      i_clk_en,
   input  wire logic                      i_hsel,
   input  wire logic [31:0]               i_haddr,
   input  wire logic [1:0]                i_htrans,
   input  wire logic                      i_hwrite,
   input  wire logic [2:0]                i_hsize,
   input  wire logic [31:0]               i_hwdata,
   input  wire logic                      i_hready,
   input  wire logic [NUM_CHAN-1:0][7:0]  i_sense_level,
   input  wire logic [NUM_DUAL-1:0]       i_dual_pin,
   output logic [31:0]                    o_hrdata,
   output logic                           o_hreadyout,
   output logic                           o_hresp,
   output logic [NUM_CHAN-1:0]            o_fault,
   output logic [NUM_DUAL-1:0]            o_logic_level
);

   // ****************************************
   // Decode helpers
   // ****************************************
   // Forces a range select onto one the channel's input actually offers
   function automatic logic [1:0] legal_range(input int ch, input logic [1:0] sel);
      logic [1:0] res;
      res = sel;
      if (ch == HV_CHAN) begin
         if (sel < RANGE_2500) res = RANGE_2500;
      end else if (ch < FIRST_DUAL) begin
         if (sel == RANGE_6000) res = RANGE_2500;
      end else begin
         res = RANGE_0573;
      end
      return res;
   endfunction

   function automatic logic [31:0] range_word(input logic [1:0] sel);
      logic [31:0] res;
      case (sel)
         RANGE_0573: res = {SPN_MV_0, BOT_MV_0};
         RANGE_1250: res = {SPN_MV_1, BOT_MV_1};
         RANGE_2500: res = {SPN_MV_2, BOT_MV_2};
         default:    res = {SPN_MV_3, BOT_MV_3};
      endcase
      return res;
   endfunction

   // Channel index of a per-channel register, or NUM_CHAN if out of bank
   function automatic int chan_of(input logic [7:0] ofs, input logic [7:0] base);
      int res;
      res = NUM_CHAN;
      if (ofs >= base && ofs < base + 8'(4 * NUM_CHAN) && ofs[1:0] == 2'h0) begin
         res = int'((ofs - base) >> 2);
      end
      return res;
   endfunction

   sfd_chan_cfg_type [NUM_CHAN-1:0]  cfg;
   logic [NUM_CHAN-1:0][6:0]         filt_us;
   logic [NUM_CHAN-1:0]              uv_flag;
   logic [NUM_CHAN-1:0]              ov_flag;
   logic [NUM_CHAN-1:0]              raw_fault;
   logic [NUM_CHAN-1:0]              filt_in;
   logic [NUM_CHAN-1:0]              filt_out;
   logic [NUM_DUAL-1:0]              pin_meta;
   logic [NUM_DUAL-1:0]              pin_sync;
   sfd_bus_req_type                  req;
   logic [31:0]                      next_rdata;
   logic                             addr_take;

   // ****************************************
   // AHB-Lite slave
   // ****************************************
   // Zero wait state; the bus must stay idle while the clock enable is low
   assign addr_take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_hreadyout <= 1'b0;
         o_hresp     <= 1'b0;
      end else if (i_clk_en) begin
         o_hreadyout <= 1'b1;
         o_hresp     <= 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         req <= '0;
      end else if (i_clk_en) begin
         req.valid <= addr_take;
         req.write <= i_hwrite;
         req.ofs   <= i_haddr[7:0];
      end
   end

   always_comb begin
      int cc;
      int cf;
      int cr;
      next_rdata = 32'h0000_0000;
      cc = chan_of(i_haddr[7:0], OFS_CFG_BASE);
      cf = chan_of(i_haddr[7:0], OFS_FILT_BASE);
      cr = chan_of(i_haddr[7:0], OFS_RANGE_BASE);
      if (i_haddr[31:8] != 24'h00_0000) begin
         next_rdata = 32'h0000_0000;
      end else if (cc < NUM_CHAN) begin
         next_rdata = 32'(cfg[cc]);
      end else if (cf < NUM_CHAN) begin
         next_rdata = 32'(filt_us[cf]);
      end else if (cr < NUM_CHAN) begin
         next_rdata = range_word(cfg[cr].range);                   // [RULE_04]
      end else if (i_haddr[7:0] == OFS_STATUS) begin
         // Detector flags only, so a logic-mode pin never reads back as a fault
         next_rdata = 32'(o_fault);                                          // [RULE_02]
      end else if (i_haddr[7:0] == OFS_RAW) begin
         next_rdata = 32'(raw_fault);
      end else if (i_haddr[7:0] == OFS_LOGIC) begin
         next_rdata = 32'(o_logic_level);
      end
   end

   // Read data captured at the address phase, valid through the data phase
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_hrdata <= 32'h0000_0000;
      end else if (i_clk_en && addr_take && !i_hwrite) begin
         o_hrdata <= next_rdata;
      end
   end

   // ****************************************
   // Per-channel configuration
   // ****************************************
   generate
      for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_cfg        // [RULE_01]
         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               cfg[ch] <= '0;
               cfg[ch].range <= legal_range(ch, 2'h0);
            end else if (i_clk_en && req.valid && req.write &&
                         chan_of(req.ofs, OFS_CFG_BASE) == ch) begin
               cfg[ch].uv_thr  <= i_hwdata[CFG_UV_LSB +: 8];        // [RULE_04]
               cfg[ch].ov_thr  <= i_hwdata[CFG_OV_LSB +: 8];
               cfg[ch].hyst    <= i_hwdata[CFG_HYST_LSB +: 5];      // [RULE_07]
               cfg[ch].mode    <= (i_hwdata[CFG_MODE_LSB +: 2] > MODE_WINDOW) ?
                                  MODE_WINDOW : i_hwdata[CFG_MODE_LSB +: 2];   // [RULE_03]
               cfg[ch].range   <= legal_range(ch, i_hwdata[CFG_RANGE_LSB +: 2]); // [RULE_05]
               cfg[ch].digital <= (ch >= FIRST_DUAL) && i_hwdata[CFG_DIG_BIT];  // [RULE_02]
            end
         end

         // Timeout in microseconds, clamped to the documented ceiling
         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               filt_us[ch] <= 7'h00;
            end else if (i_clk_en && req.valid && req.write &&
                         chan_of(req.ofs, OFS_FILT_BASE) == ch) begin
               filt_us[ch] <= (i_hwdata[FILT_US_W-1:0] > FILT_MAX_US_CODE) ?
                              FILT_MAX_US_CODE : i_hwdata[FILT_US_W-1:0];       // [RULE_08]
            end
         end
      end
   endgenerate

   // ****************************************
   // Comparators with hysteresis
   // ****************************************
   // Level codes share the threshold scale, so the hysteresis code adds directly
   generate
      for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_cmp
         logic [8:0] uv_release;
         logic [8:0] ov_release;
         logic       cmp_on;
         assign uv_release = {1'b0, cfg[ch].uv_thr} + {4'h0, cfg[ch].hyst};   // [RULE_06]
         assign ov_release = {1'b0, cfg[ch].ov_thr} - {4'h0, cfg[ch].hyst};
         assign cmp_on     = !cfg[ch].digital;

         // Evaluated on every enabled cycle, no sampling window
         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               uv_flag[ch] <= 1'b0;
            end else if (i_clk_en) begin
               if (!cmp_on) begin
                  uv_flag[ch] <= 1'b0;                                          // [RULE_02]
               end else if (!uv_flag[ch]) begin
                  uv_flag[ch] <= i_sense_level[ch] < cfg[ch].uv_thr;            // [RULE_11]
               end else begin
                  uv_flag[ch] <= !({1'b0, i_sense_level[ch]} > uv_release);     // [RULE_06]
               end
            end
         end

         always_ff @(posedge i_sys_clk) begin
            if (!i_resetn) begin
               ov_flag[ch] <= 1'b0;
            end else if (i_clk_en) begin
               if (!cmp_on) begin
                  ov_flag[ch] <= 1'b0;
               end else if (!ov_flag[ch]) begin
                  ov_flag[ch] <= i_sense_level[ch] > cfg[ch].ov_thr;            // [RULE_11]
               end else begin
                  // Release level below zero means the fault never clears
                  ov_flag[ch] <= ov_release[8] ||
                                 !({1'b0, i_sense_level[ch]} < ov_release);     // [RULE_06]
               end
            end
         end

         always_comb begin
            case (cfg[ch].mode)
               MODE_UNDER: raw_fault[ch] = uv_flag[ch];                         // [RULE_03]
               MODE_OVER:  raw_fault[ch] = ov_flag[ch];
               default:    raw_fault[ch] = uv_flag[ch] | ov_flag[ch];           // [RULE_12]
            endcase
         end

         chk_uv_set_follows: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_11]
            (i_clk_en && cmp_on && !uv_flag[ch] && i_sense_level[ch] < cfg[ch].uv_thr) |=> uv_flag[ch])
            else $error("undervoltage not flagged next cycle");

         chk_uv_hyst_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_06]
            (i_clk_en && cmp_on && uv_flag[ch] && {1'b0, i_sense_level[ch]} <= uv_release)
            |=> uv_flag[ch])
            else $error("undervoltage cleared inside hysteresis");

         chk_ov_hyst_clear: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_06]
            (i_clk_en && cmp_on && ov_flag[ch] && !ov_release[8] &&
             {1'b0, i_sense_level[ch]} < ov_release) |=> !ov_flag[ch])
            else $error("overvoltage not cleared below release level");

         chk_window_or_mode: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_12]
            (cfg[ch].mode == MODE_WINDOW) |-> (raw_fault[ch] == (uv_flag[ch] | ov_flag[ch])))
            else $error("window fault is not the OR of both comparators");

         chk_range_legal: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_05]
            cfg[ch].range == legal_range(ch, cfg[ch].range))
            else $error("channel holds a range its input does not offer");

         chk_filter_limit: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_08]
            filt_us[ch] <= FILT_MAX_US_CODE)
            else $error("filter timeout above ceiling");
      end
   endgenerate

   // ****************************************
   // Logic inputs on dual-function pins
   // ****************************************
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else if (i_clk_en) begin
         pin_meta <= i_dual_pin;
         pin_sync <= pin_meta;
      end
   end

   // Filter input: comparator result, or the synced pin in logic mode
   generate
      for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_sel
         if (ch >= FIRST_DUAL) begin : g_dual
            assign filt_in[ch] = cfg[ch].digital ? pin_sync[ch-FIRST_DUAL] : raw_fault[ch];   // [RULE_02]
         end else begin : g_ded
            assign filt_in[ch] = raw_fault[ch];
         end
      end
   endgenerate

   // ****************************************
   // Glitch filters
   // ****************************************
   generate
      for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_filt
         logic [FILT_CNT_W-1:0] limit_cyc;
         assign limit_cyc = FILT_CNT_W'(filt_us[ch] * CYC_PER_US);               // [RULE_10]
         sfd_glitch_filter u_filt (
            .i_sys_clk  (i_sys_clk),
            .i_resetn   (i_resetn),
            .i_clk_en   (i_clk_en),
            .i_raw      (filt_in[ch]),
            .i_limit    (limit_cyc),
            .o_filtered (filt_out[ch])                                           // [RULE_08]
         );
      end
   endgenerate

   // Detector flag and logic level never both active on one pin
   always_ff @(posedge i_sys_clk) begin
      if (!i_resetn) begin
         o_fault       <= '0;
         o_logic_level <= '0;
      end else if (i_clk_en) begin
         for (int ch = 0; ch < NUM_CHAN; ch++) begin
            o_fault[ch] <= filt_out[ch] && !cfg[ch].digital;                     // [RULE_02]
         end
         for (int d = 0; d < NUM_DUAL; d++) begin
            o_logic_level[d] <= filt_out[d+FIRST_DUAL] && cfg[d+FIRST_DUAL].digital;
         end
      end
   end

   chk_dual_exclusive: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_02]
      !(|(o_fault[NUM_CHAN-1:FIRST_DUAL] & o_logic_level)))
      else $error("dual pin active as detector and logic input");

   chk_bus_okay: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
      ##1 (o_hresp == 1'b0))
      else $error("slave answered with error");

endmodule

// ### dv/sfd_rail_model.sv
module sfd_rail_model
   import sfd_pkg::*;
(
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_slow,
   input  wire logic [NUM_CHAN-1:0][7:0] i_target,
   input  wire logic [NUM_DUAL-1:0]      i_dual_target,
   output logic      [NUM_CHAN-1:0][7:0] o_sense_level,
   output logic      [NUM_DUAL-1:0]      o_dual_pin
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // Rails
   // ****************************************
   initial begin
      o_sense_level = '0;
      o_dual_pin    = '0;
   end

   // Slow rails slew one code a cycle, so levels cross thresholds gradually
   always @(posedge i_sys_clk) begin
      for (int c = 0; c < NUM_CHAN; c++) begin
         if (!i_slow || o_sense_level[c] == i_target[c]) begin
            o_sense_level[c] <= i_target[c];
         end else if (o_sense_level[c] < i_target[c]) begin
            o_sense_level[c] <= o_sense_level[c] + 8'h01;
         end else begin
            o_sense_level[c] <= o_sense_level[c] - 8'h01;
         end
      end
      o_dual_pin <= i_dual_target;
   end
endmodule

// ### dv/tb.sv
module tb;
   import sfd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // Signals
   // ****************************************
   logic                     clk;
   logic                     resetn;
   logic                     clk_en;
   logic [31:0]              haddr;
   logic [1:0]               htrans;
   logic                     hwrite;
   logic [31:0]              hwdata;
   logic [31:0]              hrdata;
   logic                     hreadyout;
   logic                     slow;
   logic [NUM_CHAN-1:0][7:0] tgt;
   logic [NUM_CHAN-1:0][7:0] sense;
   logic [NUM_DUAL-1:0]      pin_tgt;
   logic [NUM_DUAL-1:0]      pin;
   logic [NUM_CHAN-1:0]      fault;
   logic [NUM_DUAL-1:0]      lvl_out;
   int                       err_total;
   int                       checks_done;
   bit                       cmp_on;
   logic [NUM_CHAN-1:0]      uvf;
   logic [NUM_CHAN-1:0]      ovf;
   logic [NUM_CHAN-1:0]      fo;
   logic [NUM_CHAN-1:0]      mf;
   logic [NUM_CHAN-1:0]      dg;
   int                       uv[NUM_CHAN];
   int                       ov[NUM_CHAN];
   int                       hy[NUM_CHAN];
   int                       md[NUM_CHAN];
   int                       tt[NUM_CHAN];
   int                       cnt[NUM_CHAN];

   sfd_channels_top u_sfd_channels_top (
      .i_sys_clk     (clk),
      .i_resetn      (resetn),
      .i_clk_en      (clk_en),
      .i_hsel        (1'b1),
      .i_haddr       (haddr),
      .i_htrans      (htrans),
      .i_hwrite      (hwrite),
      .i_hsize       (3'h2),
      .i_hwdata      (hwdata),
      .i_hready      (hreadyout),
      .i_sense_level (sense),
      .i_dual_pin    (pin),
      .o_hrdata      (hrdata),
      .o_hreadyout   (hreadyout),
      .o_hresp       (),
      .o_fault       (fault),
      .o_logic_level (lvl_out)
   );

   sfd_rail_model u_sfd_rail_model (
      .i_sys_clk     (clk),
      .i_slow        (slow),
      .i_target      (tgt),
      .i_dual_target (pin_tgt),
      .o_sense_level (sense),
      .o_dual_pin    (pin)
   );

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ****************************************
   // Reference model
   // ****************************************
   function automatic logic sel(int c);
      return md[c] == 0 ? uvf[c] : md[c] == 1 ? ovf[c] : (uvf[c] | ovf[c]);
   endfunction

   always @(posedge clk) begin
      int l;
      if (!resetn) begin
         uvf = '0;
         ovf = '0;
         fo  = '0;
         mf  = '0;
         foreach (cnt[c]) cnt[c] = 0;
      end else if (clk_en) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            mf[c] = fo[c];
            if (sel(c) == fo[c]) cnt[c] = 0;
            else if (cnt[c] >= tt[c]) begin
               fo[c]  = sel(c);
               cnt[c] = 0;
            end else cnt[c]++;
            l = sense[c];
            if (uvf[c]) uvf[c] = !(l > uv[c] + hy[c]);
            else uvf[c] = l < uv[c];
            if (ovf[c]) ovf[c] = !(ov[c] - hy[c] >= 0 && l < ov[c] - hy[c]);
            else ovf[c] = l > ov[c];
            if (dg[c]) {uvf[c], ovf[c]} = 2'h0;
         end
      end
   end

   // ****************************************
   // Checks and bus
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
      end
   endtask

   always @(negedge clk) begin
      if (cmp_on) chk(32'(fault), 32'(mf));
   end

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      haddr  <= {24'h00_0000, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0000_0000, q);
      chk(q, e);
   endtask

   // Register writes happen only while all rails sit at a no-fault level
   task automatic cfg(int c, int u, int o, int h, int m, int d, int us);
      wr(OFS_CFG_BASE + 8'(4 * c), 32'(u | o << 8 | h << 16 | m << 21 | d << 25));
      wr(OFS_FILT_BASE + 8'(4 * c), 32'(us));
      @(negedge clk);
      uv[c] = u;
      ov[c] = o;
      hy[c] = h;
      md[c] = (m == 3) ? 2 : m;
      dg[c] = 1'(d);
      tt[c] = us * CYC_PER_US;
      @(posedge clk);
   endtask

   function automatic int exp_rng(int c, int r);
      if (c == HV_CHAN) return (r < 2) ? 2 : r;
      if (c < FIRST_DUAL) return (r == 3) ? 2 : r;
      return 0;
   endfunction

   function automatic logic [31:0] exp_span(int r);
      case (r)
         0: return {SPN_MV_0, BOT_MV_0};
         1: return {SPN_MV_1, BOT_MV_1};
         2: return {SPN_MV_2, BOT_MV_2};
         default: return {SPN_MV_3, BOT_MV_3};
      endcase
   endfunction

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      int chs[3];
      int s;
      chs = '{0, 1, 5};
      {resetn, slow, cmp_on, haddr, htrans, hwrite, hwdata, tgt, pin_tgt, dg} = '0;
      clk_en = 1'b1;
      s = $urandom(32'h0000_eb01);
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      cmp_on = 1'b1;
      repeat (2) @(posedge clk);
      rd_chk(OFS_CFG_BASE, 32'h0100_0000);
      rd_chk(OFS_RANGE_BASE, exp_span(2));
      wr(8'hFC, 32'hFFFF_FFFF);
      rd_chk(8'hFC, 32'h0000_0000);
      for (int c = 0; c < NUM_CHAN; c++) cfg(c, 0, 255, 0, 0, 0, 0);
      tgt <= {NUM_CHAN{8'h80}};
      foreach (chs[i]) for (int r = 0; r < 4; r++) begin
         wr(OFS_CFG_BASE + 8'(4 * chs[i]), 32'(r << 23 | r << 21) | 32'h0000_FF00);
         rd_chk(OFS_CFG_BASE + 8'(4 * chs[i]), 32'(exp_rng(chs[i], r) << 23 | (r == 3 ? 2 : r) << 21) | 32'h0000_FF00);
         rd_chk(OFS_RANGE_BASE + 8'(4 * chs[i]), exp_span(exp_rng(chs[i], r)));
      end
      wr(OFS_FILT_BASE, 32'h0000_0065);
      rd_chk(OFS_FILT_BASE, 32'(FILT_MAX_US));
      for (int k = 0; k < 3; k++) begin
         for (int c = 0; c < NUM_CHAN; c++) begin
            cfg(c, $urandom_range(90), $urandom_range(223, 160), $urandom_range(31), $urandom_range(3),
                (c >= FIRST_DUAL) ? $urandom_range(1) : 0, $urandom_range(2));
         end
         repeat (40) begin
            slow    <= 1'($urandom_range(1));
            pin_tgt <= 5'($urandom);
            for (int c = 0; c < NUM_CHAN; c++) tgt[c] <= 8'($urandom_range(255));
            repeat ($urandom_range(60, 1)) begin
               @(posedge clk);
               clk_en <= ($urandom_range(7) != 0);
            end
         end
         @(posedge clk);
         clk_en <= 1'b1;
         slow   <= 1'b0;
         tgt    <= {NUM_CHAN{8'h80}};
         repeat (90) @(posedge clk);
         chk(32'(lvl_out), 32'(pin_tgt & dg[NUM_CHAN-1:FIRST_DUAL]));
         rd_chk(OFS_LOGIC, 32'(pin_tgt & dg[NUM_CHAN-1:FIRST_DUAL]));
         rd_chk(OFS_STATUS, 32'h0000_0000);
         rd_chk(OFS_RAW, 32'h0000_0000);
         // Pins parked low, so a channel leaving logic mode starts from a clear filter
         pin_tgt <= '0;
         repeat (60) @(posedge clk);
      end
      conclude();
   end

   initial begin
      repeat (30000) @(posedge clk);
      err_total++;
      conclude();
   end
endmodule
